// ==== lockctl_pkg.sv ====
// Purpose: shared constants for the lock and status pin controller
// Assumes: 250 MHz pclk, byte-wide flash bus, APB register access
// Notes: command bytes and flash timing are plain defaults, adjust per part
package lockctl_pkg;
  // ----------------------------------------------------------------------
  // clock and flash bus timing
  // ----------------------------------------------------------------------
  localparam int CLK_PS = 4000;
  localparam int WE_LOW_NS = 70;
  localparam int RD_ACCESS_NS = 150;
  localparam int STS_PULSE_NS = 250;
  // least times round up
  localparam int WE_LOW_CYC = (WE_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RD_CYC = (RD_ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // typical pulse, rounded down; a low run beyond four of these is busy
  localparam int STS_PULSE_CYC = (STS_PULSE_NS * 1000) / CLK_PS;
  localparam int STS_PULSE_MAX = 4 * STS_PULSE_CYC;

  localparam int ADDR_W = 23;
  localparam int DQ_W = 8;
  localparam int CNT_W = 10;

  // ----------------------------------------------------------------------
  // flash command bytes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_CONFIG = 8'hB8;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_SET_CONFIRM = 8'h01;
  localparam logic [7:0] CMD_CLR_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

  // flash status byte bit positions
  localparam int SR_READY = 7;
  localparam int SR_CLR_ERR = 5;
  localparam int SR_PGM_ERR = 4;
  localparam int SR_SUPPLY = 3;
  localparam int SR_LOCKED = 1;

  // ----------------------------------------------------------------------
  // APB register map and fields
  // ----------------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_ADDR = 12'h004;
  localparam logic [11:0] REG_CFG = 12'h008;
  localparam logic [11:0] REG_STAT = 12'h00C;

  localparam int CTRL_GO = 31;
  localparam int CTRL_FRESET = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_REFUSED = 2;
  localparam int STAT_REPEAT = 3;
  localparam int STAT_AUTOCLR = 4;
  localparam int STAT_SR_LO = 8;
  localparam int STAT_STS = 16;
  localparam int STAT_MODE_LO = 17;
  localparam int STAT_CNT_LO = 24;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_CONFIG,
    OP_SET_LOCK,
    OP_CLEAR_LOCK,
    OP_READ_STATUS,
    OP_CLEAR_STATUS
  } op_t;
endpackage

// ==== low_pulse_counter.sv ====
// Purpose: counts completion pulses on the status output pin
// Assumes: pin already synchronous to pclk
// Notes: a low run longer than the pulse limit is a busy level, not counted
`timescale 1ns/1ps
module low_pulse_counter #(
  parameter int MAX_LOW = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and mode
  input wire logic pin,
  input wire logic enable,
  // result
  output logic [7:0] count
);
  import lockctl_pkg::*;

  logic [CNT_W-1:0] run;
  logic pin_q;

  // ----------------------------------------------------------------------
  // low run length
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= '0;
      pin_q <= 1'b1;
    end else begin
      pin_q <= pin;
      if (pin) begin
        run <= '0;
      end else if (run != '1) begin
        run <= run + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // one count per rising edge after a short low run
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 8'h00;
    end else if (enable && pin && !pin_q && run != '0 &&
                 run <= CNT_W'(MAX_LOW)) begin
      count <= count + 8'h01;
    end
  end
endmodule

// ==== lock_sts_host.sv ====
// Purpose: host controller issuing lock and status pin config sequences
// Assumes: byte-wide asynchronous flash, APB software access
// Notes: one command at a time; a go while busy is refused, not queued
`timescale 1ns/1ps
// What this block does
// - set-lock is setup with block address, then confirm inside that block.
// - after set-lock, check program error flag and clear status if set.
// - clear-lock is a setup cycle then a confirm cycle.
// - after clear-lock, check clear-lock error flag and clear status if set.
// - an aborted clear-lock leaves bits undefined; the host flags it in the repeat status bit and software must repeat it.
module lock_sts_host (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash bus
  output logic [lockctl_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [lockctl_pkg::DQ_W-1:0] flash_dq_in,
  output logic [lockctl_pkg::DQ_W-1:0] flash_dq_out,
  output logic flash_dq_oe_n,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_reset_n,
  input wire logic flash_sts
);
  import lockctl_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_WSET, S_WLOW, S_WREL, S_RLOW, S_RREL
  } state_t;

  state_t state;
  op_t op;
  logic [ADDR_W-1:0] addr_reg;
  logic [1:0] cfg_code;
  logic [1:0] mode_mirror;
  logic [1:0] mode_pend;
  logic freset;
  logic [7:0] byte0, byte1;
  logic two_writes, poll, second;
  logic [CNT_W-1:0] tick;
  logic [7:0] sr_byte;
  logic done, refused, repeat_clr, autoclr, clr_pend;
  logic [7:0] pulse_cnt;
  logic wr_acc, rd_acc, go;
  logic sr_err;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign go = wr_acc && paddr == REG_CTRL && pwdata[CTRL_GO];
  assign pready = 1'b1;
  assign pslverr = psel && penable && paddr != REG_CTRL &&
                   paddr != REG_ADDR && paddr != REG_CFG && paddr != REG_STAT;
  assign sr_err = flash_dq_in[SR_PGM_ERR] || flash_dq_in[SR_CLR_ERR] ||
                  flash_dq_in[SR_SUPPLY] ||
                  flash_dq_in[SR_LOCKED];

  // ----------------------------------------------------------------------
  // software settings
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= '0;
      cfg_code <= 2'b00;
      freset <= 1'b0;
    end else if (wr_acc) begin
      if (paddr == REG_ADDR) begin
        addr_reg <= pwdata[ADDR_W-1:0];
      end
      if (paddr == REG_CFG) begin
        cfg_code <= pwdata[1:0];
      end
      if (paddr == REG_CTRL) begin
        freset <= pwdata[CTRL_FRESET];
      end
    end
  end

  assign flash_reset_n = !freset;

  // ----------------------------------------------------------------------
  // mirror of the device pin mode
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_mirror <= 2'b00;
    end else if (freset) begin
      mode_mirror <= 2'b00;
    end else if (state == S_RREL && op == OP_CONFIG &&
                 flash_dq_in[SR_READY] && !clr_pend &&
                 !flash_dq_in[SR_PGM_ERR] && !flash_dq_in[SR_CLR_ERR]) begin
      mode_mirror <= mode_pend;
    end
  end

  // ----------------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      op <= OP_NONE;
      byte0 <= 8'h00;
      byte1 <= 8'h00;
      two_writes <= 1'b0;
      poll <= 1'b0;
      second <= 1'b0;
      tick <= '0;
      mode_pend <= 2'b00;
      clr_pend <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          second <= 1'b0;
          clr_pend <= 1'b0;
          tick <= '0;
          if (go && !freset) begin
            op <= op_t'(pwdata[2:0]);
            mode_pend <= cfg_code;
            state <= S_WSET;
            poll <= 1'b1;
            two_writes <= 1'b1;
            case (op_t'(pwdata[2:0]))
              OP_CONFIG: begin
                // reserved upper bits always written as zero
                byte0 <= CMD_CONFIG;
                byte1 <= {6'h00, cfg_code};
              end
              OP_SET_LOCK: begin
                byte0 <= CMD_LOCK_SETUP;
                byte1 <= CMD_SET_CONFIRM;
              end
              OP_CLEAR_LOCK: begin
                byte0 <= CMD_LOCK_SETUP;
                byte1 <= CMD_CLR_CONFIRM;
              end
              OP_READ_STATUS: begin
                byte0 <= CMD_READ_STATUS;
                two_writes <= 1'b0;
              end
              OP_CLEAR_STATUS: begin
                byte0 <= CMD_CLEAR_STATUS;
                two_writes <= 1'b0;
                poll <= 1'b0;
              end
              default: begin
                state <= S_IDLE;
              end
            endcase
          end
        end
        S_WSET: begin
          state <= S_WLOW;
          tick <= '0;
        end
        S_WLOW: begin
          tick <= tick + 1'b1;
          if (tick == CNT_W'(WE_LOW_CYC - 1)) begin
            state <= S_WREL;
          end
        end
        S_WREL: begin
          tick <= '0;
          if (two_writes && !second) begin
            second <= 1'b1;
            state <= S_WSET;
          end else if (poll) begin
            state <= S_RLOW;
          end else begin
            state <= S_IDLE;
          end
        end
        S_RLOW: begin
          tick <= tick + 1'b1;
          if (tick == CNT_W'(RD_CYC - 1)) begin
            state <= S_RREL;
          end
        end
        S_RREL: begin
          tick <= '0;
          if (!flash_dq_in[SR_READY]) begin
            state <= S_RLOW;
          end else if (sr_err && !clr_pend) begin
            // error seen: clear the flash status before reporting
            clr_pend <= 1'b1;
            byte0 <= CMD_CLEAR_STATUS;
            two_writes <= 1'b0;
            second <= 1'b0;
            poll <= 1'b0;
            state <= S_WSET;
          end else begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // flash pin drive
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_addr <= '0;
      flash_dq_out <= 8'h00;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end else begin
      // select and data outlast the write strobe by a clock for hold time
      flash_ce_n <= !(state == S_WSET || state == S_WLOW ||
                      state == S_WREL || state == S_RLOW);
      flash_we_n <= !(state == S_WSET || state == S_WLOW);
      // read strobe spans each S_RLOW read, one clock behind state, and is released for a clock between polls
      flash_oe_n <= !(state == S_RLOW);
      flash_dq_oe_n <= !(state == S_WSET || state == S_WLOW ||
                         state == S_WREL);
      if (state == S_WSET) begin
        // both cycles of a lock sequence use the same block address
        flash_addr <= addr_reg;
        flash_dq_out <= second ? byte1 : byte0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // status capture and sticky flags
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_byte <= 8'h00;
      done <= 1'b0;
      refused <= 1'b0;
      repeat_clr <= 1'b0;
      autoclr <= 1'b0;
    end else begin
      if (state == S_RREL && flash_dq_in[SR_READY] && !clr_pend) begin
        sr_byte <= flash_dq_in;
        autoclr <= sr_err;
        // failed clear leaves bits unknown; software must repeat it
        repeat_clr <= op == OP_CLEAR_LOCK &&
                      (flash_dq_in[SR_CLR_ERR] ||
                       flash_dq_in[SR_SUPPLY]);
      end
      if (go && state != S_IDLE) begin
        refused <= 1'b1;
      end else if (go) begin
        refused <= 1'b0;
      end
      // set wins over a software clear in the same cycle
      if ((state == S_RREL && flash_dq_in[SR_READY] && !sr_err) ||
          (state == S_WREL && !poll)) begin
        done <= 1'b1;
      end else if (wr_acc && paddr == REG_STAT && pwdata[STAT_DONE]) begin
        done <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // status pin pulse counting
  // ----------------------------------------------------------------------
  low_pulse_counter #(
    .MAX_LOW(STS_PULSE_MAX)
  ) u_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .pin(flash_sts),
    .enable(mode_mirror != 2'b00),
    .count(pulse_cnt)
  );

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        REG_CTRL: prdata <= {23'h0, freset, 5'h00, op};
        REG_ADDR: prdata <= {9'h000, addr_reg};
        REG_CFG: prdata <= {30'h0, cfg_code};
        REG_STAT: prdata <= {pulse_cnt, 5'h00, mode_mirror, flash_sts,
                             sr_byte, 3'h0, autoclr, repeat_clr, refused,
                             done, state != S_IDLE};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ==== lock_sts_host_sva.sv ====
// Purpose: bus and flash strobe checks for lock_sts_host
// Assumes: top module ports only, one clock
// Notes: device flags are judged by the bench
`timescale 1ns/1ps
module lock_sts_host_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // flash
  input wire logic [lockctl_pkg::DQ_W-1:0] flash_dq_out,
  input wire logic flash_dq_oe_n,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_reset_n
);
  import lockctl_pkg::*;
  // ----
  // strobe length counters
  // ----
  logic [7:0] we_lo;
  logic [7:0] rd_lo;
  logic acc;
  logic mapped;
  logic fr_bit;
  assign acc = psel && penable;
  assign mapped = paddr inside {REG_CTRL, REG_ADDR, REG_CFG, REG_STAT};
  assign fr_bit = pwdata[CTRL_FRESET];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) we_lo <= 8'h00;
    else we_lo <= flash_we_n ? 8'h00 : we_lo + 8'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rd_lo <= 8'h00;
    else rd_lo <= flash_oe_n ? 8'h00 : rd_lo + 8'h01;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_always: assert property (pready)
    else $error("pready dropped");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped word");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped word");
  a_we_width: assert property ($rose(flash_we_n) |-> we_lo >= WE_LOW_CYC)
    else $error("write strobe too short");
  a_rd_width: assert property ($rose(flash_oe_n) |-> rd_lo >= RD_CYC)
    else $error("read strobe too short");
  a_write_drives: assert property (
    !flash_we_n |-> !flash_ce_n && !flash_dq_oe_n)
    else $error("write without select or data drive");
  a_read_no_fight: assert property (
    !flash_oe_n |-> flash_dq_oe_n && flash_we_n)
    else $error("host drives data during read");
  a_data_hold: assert property (
    !flash_we_n ##1 !flash_we_n |-> $stable(flash_dq_out))
    else $error("data moved under write strobe");
  a_freset_write: assert property (
    acc && pwrite && paddr == REG_CTRL |=> flash_reset_n == !$past(fr_bit))
    else $error("flash reset not per control write");
  a_quiet_reset: assert property (!flash_reset_n |-> flash_ce_n)
    else $error("flash selected during reset");
  c_unmapped: cover property (acc && !mapped);
  c_write: cover property ($rose(flash_we_n));
  c_freset: cover property (!flash_reset_n);
endmodule

bind lock_sts_host lock_sts_host_sva chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .flash_dq_out,
  .flash_dq_oe_n, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_reset_n);

// ==== flash_lock_model.sv ====
// Purpose: behavioural flash for lock and status pin commands
// Assumes: commands latched on the rising write strobe
// Notes: set-lock counts as program, clear-lock as erase for pulses
`timescale 1ns/1ps
module flash_lock_model #(
  parameter int BUSY_NS = 2000,
  parameter int PULSE_NS = 250
) (
  // host side
  input wire logic [lockctl_pkg::ADDR_W-1:0] addr,
  input wire logic [lockctl_pkg::DQ_W-1:0] dq_in,
  input wire logic dq_oe_n,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic reset_n,
  // supply and outputs
  input wire logic supply_low,
  output logic [lockctl_pkg::DQ_W-1:0] dq_out,
  output logic sts
);
  import lockctl_pkg::*;
  // ----
  // command state
  // ----
  logic [7:0] sr = 8'h80;
  logic [1:0] mode = 2'h0;
  logic [63:0] lock = '0;
  logic [7:0] first = 8'h00;
  logic [7:0] wd;
  logic busy = 1'h0;
  logic pulse = 1'h0;
  // released bus shows no stale byte
  assign dq_out = (!ce_n && !oe_n) ? sr : ~sr;
  assign sts = (mode == 2'h0) ? !busy : !pulse;
  task automatic finish(input logic set_kind, input logic [5:0] blk);
    #(BUSY_NS);
    if (supply_low) sr[5:3] = set_kind ? 3'h3 : 3'h5;
    else if (set_kind) lock[blk] = 1'h1;
    else lock = '0;
    busy = 1'h0;
    sr[7] = 1'h1;
    if (mode[set_kind]) begin
      pulse = 1'h1;
      #(PULSE_NS);
      pulse = 1'h0;
    end
  endtask
  always @(negedge reset_n) mode = 2'h0;
  always @(posedge we_n) begin
    if (!ce_n && reset_n) begin
      wd = dq_oe_n ? 8'hFF : dq_in;
      if (first == CMD_CONFIG) begin
        if (wd[7:2] != 6'h00) sr[5:4] = 2'h3;
        else mode = wd[1:0];
        first = 8'h00;
      end else if (first == CMD_LOCK_SETUP) begin
        if (wd == CMD_SET_CONFIRM || wd == CMD_CLR_CONFIRM) begin
          busy = 1'h1;
          sr[7] = 1'h0;
          fork
            finish(wd == CMD_SET_CONFIRM, addr[22:17]);
          join_none
        end else sr[5:4] = 2'h3;
        first = 8'h00;
      end else if (!busy && (wd == CMD_CONFIG || wd == CMD_LOCK_SETUP))
        first = wd;
      else if (wd == CMD_CLEAR_STATUS)
        sr[5:1] = 5'h00;
    end
  end
endmodule

// ==== test_lock_sts_host.sv ====
// Purpose: self-checking bench for lock_sts_host
// Assumes: zero wait apb, behavioural flash partner
// Notes: lock bits are read from the partner directly
`timescale 1ns/1ps
module test_lock_sts_host;
  import lockctl_pkg::*;
  localparam int BUSY_NS = 2000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, st, q;
  logic [ADDR_W-1:0] fa;
  logic [DQ_W-1:0] h2f, f2h;
  logic dq_oe_n, ce_n, we_n, oe_n, fres_n, fsts, supply_low;
  int error_cnt, checks, cyc, lows, expc;
  lock_sts_host uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(fa),
    .flash_dq_in(f2h), .flash_dq_out(h2f), .flash_dq_oe_n(dq_oe_n),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_reset_n(fres_n), .flash_sts(fsts));
  flash_lock_model #(.BUSY_NS(BUSY_NS), .PULSE_NS(250)) model (.addr(fa),
    .dq_in(h2f), .dq_oe_n(dq_oe_n), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .reset_n(fres_n), .supply_low(supply_low), .dq_out(f2h), .sts(fsts));
  // ----
  // clock, watchdog and tasks
  // ----
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (!fsts) lows++;
    if (cyc == 40000) begin
      error_cnt++;
      $display("[FAIL] %0t run hung", $time);
      tally_and_finish;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic go(input logic [2:0] op, input logic [22:0] addr);
    apb(1'h1, REG_ADDR, {9'h000, addr});
    apb(1'h1, REG_CTRL, {1'h1, 28'h0, op});
  endtask
  // poll done, keep the status word, then clear done and let pulses end
  task automatic wait_done;
    int n;
    n = 0;
    st = 32'h0;
    while (st[STAT_DONE] !== 1'h1 && n < 5000) begin
      apb(1'h0, REG_STAT, 32'h0);
      st = q;
      n++;
    end
    apb(1'h1, REG_STAT, 32'h2);
    repeat (80) @(posedge pclk);
  endtask
  // ----
  // tests
  // ----
  initial begin
    {presetn, psel, penable, pwrite, supply_low} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    {error_cnt, checks, cyc, lows, expc} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, REG_STAT, 32'h0);
    check({q[31:24], q[18:17], q[4:0]}, 32'h0);
    apb(1'h1, 12'h010, 32'hFFFF_FFFF);
    check(perr, 1'h1);
    apb(1'h0, 12'h010, 32'h0);
    check({perr, q[30:0]}, 32'h8000_0000);
    $display("reset and map test done");
    lows = 0;
    go(3'h2, 23'h0A_0123);
    wait_done;
    check(st[STAT_SR_LO +: 8], 8'h80);
    check(model.lock[5:4], 2'h2);
    check(lows >= BUSY_NS / 4 - 2, 1'h1);
    $display("set lock test done");
    supply_low <= 1'h1;
    go(3'h3, 23'h0);
    wait_done;
    check(st[STAT_SR_LO +: 8], 8'hA8);
    check(st[STAT_AUTOCLR], 1'h1);
    check(st[STAT_REPEAT], 1'h1);
    go(3'h2, 23'h0C_0000);
    wait_done;
    check(st[STAT_SR_LO +: 8], 8'h98);
    check(model.lock[6:5], 2'h1);
    check(model.sr[5:1], 5'h00);
    supply_low <= 1'h0;
    $display("low supply test done");
    for (int c = 0; c < 4; c++) begin
      apb(1'h1, REG_CFG, 32'(c));
      go(3'h1, 23'h0);
      wait_done;
      check(st[STAT_MODE_LO +: 2], c[1:0]);
      go(3'h2, 23'h02_0000);
      wait_done;
      go(3'h3, 23'h0);
      wait_done;
      expc += c[0] + c[1];
      apb(1'h0, REG_STAT, 32'h0);
      check(q[STAT_CNT_LO +: 8], expc[7:0]);
      check({31'h0, |model.lock}, 32'h0);
    end
    $display("mode and pulse test done");
    go(3'h2, 23'h04_0000);
    apb(1'h1, REG_CTRL, {1'h1, 28'h0, 3'h3});
    apb(1'h0, REG_STAT, 32'h0);
    check(q[STAT_REFUSED], 1'h1);
    wait_done;
    check(model.lock[2], 1'h1);
    $display("refusal test done");
    apb(1'h1, REG_CTRL, 32'h0000_0100);
    apb(1'h0, REG_CTRL, 32'h0);
    check({fres_n, q[8]}, 2'h1);
    apb(1'h1, REG_CTRL, 32'h0);
    apb(1'h0, REG_STAT, 32'h0);
    check(q[STAT_MODE_LO +: 2], 2'h0);
    check(model.mode, 2'h0);
    $display("flash reset test done");
    tally_and_finish;
  end
endmodule
